// ### faopr_pkg.sv
// shared constants and types for the flash address/option/protect register block
package faopr_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_TARGET    = 32'h0000_0014; // program/erase target
  localparam logic [31:0] ADDR_OPTION    = 32'h0000_001c; // option settings status
  localparam logic [31:0] ADDR_WPROT     = 32'h0000_0020; // write protect status
  localparam logic [31:0] ADDR_KEY       = 32'h0000_0024; // fast mode unlock key
  localparam logic [31:0] ADDR_IRQ_STAT  = 32'h0000_0028; // event status, write one to clear
  localparam logic [31:0] ADDR_IRQ_MASK  = 32'h0000_002c; // event mask

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int          OPT_ERR_BIT    = 0;              // option word mismatch
  localparam int          OPT_RDP_BIT    = 1;              // read protect active
  localparam int          OPT_USER_LSB   = 2;              // user field low bit
  localparam int          OPT_USER_MSB   = 7;              // user field high bit
  localparam logic [31:0] FIRST_UNLOCK   = 32'h4567_0123;  // first unlock value
  localparam logic [31:0] SECOND_UNLOCK  = 32'hcdef_89ab;  // second unlock value
  localparam int          IRQ_W          = 4;              // number of event bits
  localparam int          IRQ_UNLOCK_OK  = 0;              // fast mode unlocked
  localparam int          IRQ_UNLOCK_BAD = 1;              // key sequence broken
  localparam int          IRQ_OP_DONE    = 2;              // busy fell
  localparam int          IRQ_ADDR_DROP  = 3;              // target write refused
  localparam logic [1:0]  RESP_OKAY      = 2'h0;           // normal answer
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;           // unmapped address

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TARGET_RST     = 32'h0000_0000;  // target location
  localparam logic        LOCK_RST       = 1'b1;           // fast mode locked
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;           // all events masked

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum {
    SEL_TARGET, SEL_OPTION, SEL_WPROT, SEL_KEY, SEL_ISTAT, SEL_IMASK, SEL_NONE
  } faopr_sel_t;

  typedef enum {KEY_IDLE, KEY_HALF, KEY_DEAD} faopr_key_st_t;

  typedef enum {OPT_LOAD, OPT_DONE} faopr_opt_st_t;

endpackage : faopr_pkg

// ### faopr_link_if.sv
// internal link between the register block and its key and option helpers
interface faopr_link_if;
  logic        key_wr;      // one-cycle key register write
  logic [31:0] key_data;    // value written to the key register
  logic        other_wr;    // one-cycle write to any other register
  logic        unlock_p;    // pulse: correct pair seen
  logic        fail_p;      // pulse: sequence broken
  logic [7:0]  ob_user;     // stored user option byte
  logic [7:0]  ob_user_inv; // stored complement of the user byte
  logic        ob_rdp;      // stored read protect state
  logic [31:0] ob_wrp;      // stored block protect word
  logic [5:0]  user_bits;   // loaded user field, bits 7..2
  logic        rdp;         // loaded read protect state
  logic        mismatch;    // loaded word disagrees with complement
  logic [31:0] block_protect_bits;         // loaded block protect bits

  modport regs (output key_wr, key_data, other_wr, ob_user, ob_user_inv, ob_rdp, ob_wrp,
                input  unlock_p, fail_p, user_bits, rdp, mismatch, block_protect_bits);
  modport keys (input  key_wr, key_data, other_wr, output unlock_p, fail_p);
  modport opts (input  ob_user, ob_user_inv, ob_rdp, ob_wrp,
                output user_bits, rdp, mismatch, block_protect_bits);
endinterface : faopr_link_if

// ### faopr_keyseq.sv
// fast mode key sequence checker
module faopr_keyseq (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  faopr_link_if.keys  link
);

  // all state of this module
  typedef struct packed {
    faopr_pkg::faopr_key_st_t st;     // sequence position
    logic                     unlock; // unlock pulse
    logic                     fail;   // failure pulse
  } faopr_keyst_t;

  faopr_keyst_t cur_r;                // registered state
  faopr_keyst_t cur_nxt;              // next state

  // ----------------------------------------------------------------
  // sequence decode
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_nxt        = cur_r;
    cur_nxt.unlock = 1'b0;
    cur_nxt.fail   = 1'b0;
    case (cur_r.st)
      faopr_pkg::KEY_IDLE:
      begin
        if (link.key_wr && link.key_data == faopr_pkg::FIRST_UNLOCK)
          cur_nxt.st = faopr_pkg::KEY_HALF;
        else if (link.key_wr)
        begin
          cur_nxt.st   = faopr_pkg::KEY_DEAD;
          cur_nxt.fail = 1'b1;
        end
      end
      faopr_pkg::KEY_HALF:
      begin
        if (link.key_wr && link.key_data == faopr_pkg::SECOND_UNLOCK)
        begin
          cur_nxt.st     = faopr_pkg::KEY_IDLE;
          cur_nxt.unlock = 1'b1;
        end
        else if (link.key_wr || link.other_wr)
        begin
          cur_nxt.st   = faopr_pkg::KEY_DEAD;
          cur_nxt.fail = 1'b1;
        end
      end
      default:
        cur_nxt.st = faopr_pkg::KEY_DEAD; // stays until reset
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cur_r <= '{st: faopr_pkg::KEY_IDLE, unlock: 1'b0, fail: 1'b0};
    else
      cur_r <= cur_nxt;
  end

  assign link.unlock_p = cur_r.unlock;
  assign link.fail_p   = cur_r.fail;

endmodule : faopr_keyseq

// ### faopr_optload.sv
// option byte capture after reset
module faopr_optload (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  faopr_link_if.opts  link
);

  // all state of this module
  typedef struct packed {
    faopr_pkg::faopr_opt_st_t st;       // load or done
    logic [5:0]               user;     // user field
    logic                     rdp;      // read protect
    logic                     mismatch; // complement check failed
    logic [31:0]              block_protect_bits;      // block protect bits
  } faopr_optst_t;

  faopr_optst_t cur_r;                  // registered state
  faopr_optst_t cur_nxt;                // next state

  // ----------------------------------------------------------------
  // capture once per reset
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_nxt = cur_r;
    if (cur_r.st == faopr_pkg::OPT_LOAD)
    begin
      cur_nxt.st       = faopr_pkg::OPT_DONE;
      cur_nxt.user     = link.ob_user[7:2];
      cur_nxt.rdp      = link.ob_rdp;
      cur_nxt.block_protect_bits      = link.ob_wrp;
      cur_nxt.mismatch = (link.ob_user != ~link.ob_user_inv);
    end
  end

  // state register, synchronous reset to constants only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cur_r <= '{st: faopr_pkg::OPT_LOAD, user: 6'h0, rdp: 1'b0, mismatch: 1'b0,
                 block_protect_bits: 32'h0000_0000};
    else
      cur_r <= cur_nxt;
  end

  assign link.user_bits = cur_r.user;
  assign link.rdp       = cur_r.rdp;
  assign link.mismatch  = cur_r.mismatch;
  assign link.block_protect_bits       = cur_r.block_protect_bits;

endmodule : faopr_optload

// ### faopr_regs.sv
// flash target address, option status, write protect and fast mode key registers
//
// Design decision made here: the AXI4-Lite interface to the registers.
module faopr_regs (
  aclk,
  aresetn,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_awaddr,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_bresp,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_araddr,
  s_axi_rvalid,
  s_axi_rready,
  s_axi_rdata,
  s_axi_rresp,
  op_start,
  op_done,
  lock_set,
  ob_user,
  ob_user_inv,
  ob_rdp,
  ob_wrp,
  target_location,
  busy_flag,
  fast_mode_lock,
  irq
);

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  input  wire logic        aclk;            // system clock
  input  wire logic        aresetn;         // synchronous reset, active low
  input  wire logic        s_axi_awvalid;   // write address valid
  output logic             s_axi_awready;   // write address ready
  input  wire logic [31:0] s_axi_awaddr;    // write byte address
  input  wire logic        s_axi_wvalid;    // write data valid
  output logic             s_axi_wready;    // write data ready
  input  wire logic [31:0] s_axi_wdata;     // write data
  input  wire logic [3:0]  s_axi_wstrb;     // write byte lanes
  output logic             s_axi_bvalid;    // write response valid
  input  wire logic        s_axi_bready;    // write response ready
  output logic [1:0]       s_axi_bresp;     // write response code
  input  wire logic        s_axi_arvalid;   // read address valid
  output logic             s_axi_arready;   // read address ready
  input  wire logic [31:0] s_axi_araddr;    // read byte address
  output logic             s_axi_rvalid;    // read data valid
  input  wire logic        s_axi_rready;    // read data ready
  output logic [31:0]      s_axi_rdata;     // read data
  output logic [1:0]       s_axi_rresp;     // read response code
  input  wire logic        op_start;        // sequencer starts an operation
  input  wire logic        op_done;         // sequencer finished the operation
  input  wire logic        lock_set;        // software relocks fast mode
  input  wire logic [7:0]  ob_user;         // stored user option byte
  input  wire logic [7:0]  ob_user_inv;     // stored complement of user byte
  input  wire logic        ob_rdp;          // stored read protect state
  input  wire logic [31:0] ob_wrp;          // stored block protect word
  output logic [31:0]      target_location; // program/erase target
  output logic             busy_flag;       // operation in progress
  output logic             fast_mode_lock;  // fast program/erase locked
  output logic             irq;             // level interrupt

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      awready;  // write address slot free
    logic                      wready;   // write data slot free
    logic                      aw_held;  // write address captured
    logic [31:0]               aw_addr;  // captured write address
    logic                      w_held;   // write data captured
    logic [31:0]               w_data;   // captured write data
    logic [3:0]                w_strb;   // captured byte lanes
    logic                      bvalid;   // write answer pending
    logic [1:0]                bresp;    // write answer code
    logic                      arready;  // read slot free
    logic                      rvalid;   // read answer pending
    logic [31:0]               rdata;    // read answer data
    logic [1:0]                rresp;    // read answer code
    logic [31:0]               target;   // target location
    logic                      busy;     // busy flag
    logic                      lock;     // fast mode lock
    logic                      key_wr;   // key write pulse
    logic [31:0]               key_data; // key write value
    logic                      other_wr; // non-key write pulse
    logic [faopr_pkg::IRQ_W-1:0] istat;  // sticky events
    logic [faopr_pkg::IRQ_W-1:0] imask;  // event enables
    logic                      irq;      // interrupt level
  } faopr_state_t;

  faopr_state_t cur_r;                    // registered state
  faopr_state_t cur_nxt;                  // next state

  faopr_link_if link ();                  // helper link

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address to register select, shared by read and write paths
  function automatic faopr_pkg::faopr_sel_t reg_sel(input logic [31:0] addr);
    if (addr == faopr_pkg::ADDR_TARGET)
      return faopr_pkg::SEL_TARGET;
    else if (addr == faopr_pkg::ADDR_OPTION)
      return faopr_pkg::SEL_OPTION;
    else if (addr == faopr_pkg::ADDR_WPROT)
      return faopr_pkg::SEL_WPROT;
    else if (addr == faopr_pkg::ADDR_KEY)
      return faopr_pkg::SEL_KEY;
    else if (addr == faopr_pkg::ADDR_IRQ_STAT)
      return faopr_pkg::SEL_ISTAT;
    else if (addr == faopr_pkg::ADDR_IRQ_MASK)
      return faopr_pkg::SEL_IMASK;
    else
      return faopr_pkg::SEL_NONE;
  endfunction : reg_sel

  // merge written byte lanes into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // helper modules
  // ----------------------------------------------------------------
  faopr_keyseq u_keyseq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (link.keys)
  );

  faopr_optload u_optload (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (link.opts)
  );

  // link drive: registered pulses and stored option bytes
  assign link.key_wr      = cur_r.key_wr;
  assign link.key_data    = cur_r.key_data;
  assign link.other_wr    = cur_r.other_wr;
  assign link.ob_user     = ob_user;
  assign link.ob_user_inv = ob_user_inv;
  assign link.ob_rdp      = ob_rdp;
  assign link.ob_wrp      = ob_wrp;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [faopr_pkg::IRQ_W-1:0] ev;    // events this cycle
    logic [faopr_pkg::IRQ_W-1:0] clr;   // write one to clear bits
    faopr_pkg::faopr_sel_t       wsel;  // write target
    faopr_pkg::faopr_sel_t       rsel;  // read target
    ev       = '0;
    clr      = '0;
    wsel     = reg_sel(cur_r.aw_addr);
    rsel     = reg_sel(s_axi_araddr);
    cur_nxt  = cur_r;
    cur_nxt.key_wr   = 1'b0;
    cur_nxt.other_wr = 1'b0;

    // write address channel capture
    if (s_axi_awvalid && cur_r.awready)
    begin
      cur_nxt.awready = 1'b0;
      cur_nxt.aw_held = 1'b1;
      cur_nxt.aw_addr = s_axi_awaddr;
    end

    // write data channel capture
    if (s_axi_wvalid && cur_r.wready)
    begin
      cur_nxt.wready = 1'b0;
      cur_nxt.w_held = 1'b1;
      cur_nxt.w_data = s_axi_wdata;
      cur_nxt.w_strb = s_axi_wstrb;
    end

    // both halves held: perform the write and answer
    if (cur_r.aw_held && cur_r.w_held && !cur_r.bvalid)
    begin
      cur_nxt.aw_held  = 1'b0;
      cur_nxt.w_held   = 1'b0;
      cur_nxt.bvalid   = 1'b1;
      cur_nxt.bresp    = faopr_pkg::RESP_OKAY;
      cur_nxt.other_wr = (wsel != faopr_pkg::SEL_KEY);
      if (wsel == faopr_pkg::SEL_TARGET)
      begin
        if (cur_r.busy)
          ev[faopr_pkg::IRQ_ADDR_DROP] = 1'b1;
        else
          cur_nxt.target = lane_merge(cur_r.target, cur_r.w_data, cur_r.w_strb);
      end
      else if (wsel == faopr_pkg::SEL_KEY)
      begin
        cur_nxt.key_wr   = 1'b1;
        cur_nxt.key_data = lane_merge(32'h0000_0000, cur_r.w_data, cur_r.w_strb);
      end
      else if (wsel == faopr_pkg::SEL_ISTAT)
        clr = cur_r.w_data[faopr_pkg::IRQ_W-1:0] & {faopr_pkg::IRQ_W{cur_r.w_strb[0]}};
      else if (wsel == faopr_pkg::SEL_IMASK)
      begin
        if (cur_r.w_strb[0])
          cur_nxt.imask = cur_r.w_data[faopr_pkg::IRQ_W-1:0];
      end
      else if (wsel == faopr_pkg::SEL_NONE)
        cur_nxt.bresp = faopr_pkg::RESP_SLVERR;
      // read-only registers: write dropped, normal answer
    end

    // write answer taken: reopen both channels
    if (cur_r.bvalid && s_axi_bready)
    begin
      cur_nxt.bvalid  = 1'b0;
      cur_nxt.awready = 1'b1;
      cur_nxt.wready  = 1'b1;
    end

    // read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && cur_r.arready)
    begin
      cur_nxt.arready = 1'b0;
      cur_nxt.rvalid  = 1'b1;
      cur_nxt.rresp   = faopr_pkg::RESP_OKAY;
      cur_nxt.rdata   = 32'h0000_0000;
      if (rsel == faopr_pkg::SEL_TARGET || rsel == faopr_pkg::SEL_KEY)
        cur_nxt.rdata = 32'h0000_0000;
      else if (rsel == faopr_pkg::SEL_OPTION)
      begin
        cur_nxt.rdata[faopr_pkg::OPT_USER_MSB:faopr_pkg::OPT_USER_LSB] = link.user_bits;
        cur_nxt.rdata[faopr_pkg::OPT_RDP_BIT] = link.rdp;
        cur_nxt.rdata[faopr_pkg::OPT_ERR_BIT] = link.mismatch;
      end
      else if (rsel == faopr_pkg::SEL_WPROT)
        cur_nxt.rdata = link.block_protect_bits;
      else if (rsel == faopr_pkg::SEL_ISTAT)
        cur_nxt.rdata[faopr_pkg::IRQ_W-1:0] = cur_r.istat;
      else if (rsel == faopr_pkg::SEL_IMASK)
        cur_nxt.rdata[faopr_pkg::IRQ_W-1:0] = cur_r.imask;
      else
        cur_nxt.rresp = faopr_pkg::RESP_SLVERR;
    end

    // read answer taken: reopen the read channel
    if (cur_r.rvalid && s_axi_rready)
    begin
      cur_nxt.rvalid  = 1'b0;
      cur_nxt.arready = 1'b1;
    end

    if (op_start)
      cur_nxt.busy = 1'b1;
    else if (op_done)
    begin
      cur_nxt.busy = 1'b0;
      ev[faopr_pkg::IRQ_OP_DONE] = cur_r.busy;
    end

    if (link.unlock_p)
    begin
      cur_nxt.lock = 1'b0;
      ev[faopr_pkg::IRQ_UNLOCK_OK] = 1'b1;
    end
    if (link.fail_p)
    begin
      cur_nxt.lock = 1'b1;
      ev[faopr_pkg::IRQ_UNLOCK_BAD] = 1'b1;
    end
    // software relock wins
    if (lock_set)
      cur_nxt.lock = 1'b1;

    // sticky events, a new event beats its clear
    cur_nxt.istat = (cur_r.istat & ~clr) | ev;
    cur_nxt.irq   = |(cur_nxt.istat & cur_nxt.imask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_r          <= '0;
      cur_r.awready  <= 1'b1;
      cur_r.wready   <= 1'b1;
      cur_r.arready  <= 1'b1;
      cur_r.target   <= faopr_pkg::TARGET_RST;
      cur_r.lock     <= faopr_pkg::LOCK_RST;
      cur_r.imask    <= faopr_pkg::IRQ_MASK_RST;
    end
    else
      cur_r <= cur_nxt;
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_awready   = cur_r.awready;
  assign s_axi_wready    = cur_r.wready;
  assign s_axi_bvalid    = cur_r.bvalid;
  assign s_axi_bresp     = cur_r.bresp;
  assign s_axi_arready   = cur_r.arready;
  assign s_axi_rvalid    = cur_r.rvalid;
  assign s_axi_rdata     = cur_r.rdata;
  assign s_axi_rresp     = cur_r.rresp;
  assign target_location = cur_r.target;
  assign busy_flag       = cur_r.busy;
  assign fast_mode_lock  = cur_r.lock;
  assign irq             = cur_r.irq;

endmodule : faopr_regs

// ### faopr_regs_assertions.sv
// concurrent checks on the flash target, protect and key registers
module faopr_regs_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        op_start,
  input wire logic        op_done,
  input wire logic        lock_set,
  input wire logic [31:0] ob_wrp,
  input wire logic [31:0] target_location,
  input wire logic        busy_flag,
  input wire logic        fast_mode_lock
);
  // ----------------------------------------------------------------
  // one clock domain, checks off in reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_busy_starts: assert property (op_start |=> busy_flag)
    else $error("busy did not rise after start");
  a_busy_holds: assert property (busy_flag && !op_done |=> busy_flag)
    else $error("busy fell without done");
  a_target_frozen: assert property (busy_flag |=> $stable(target_location))
    else $error("target changed while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not closed");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not closed");
  a_wprot_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == faopr_pkg::ADDR_WPROT |=> s_axi_rdata == ob_wrp)
    else $error("protect word read wrong");
  a_relock: assert property (lock_set |=> fast_mode_lock)
    else $error("lock not set again");
endmodule : faopr_regs_assertions

bind faopr_regs faopr_regs_assertions chk (.*);

// ### faopr_regs_tb.sv
// self-checking bench for the flash target, option, protect and key registers
module faopr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus, responses and scoreboard queues
  // ----------------------------------------------------------------
  logic        aclk = 0, aresetn = 0, op_start = 0, op_done = 0, lock_set = 0, ob_rdp = 1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, ob_wrp = '0, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [7:0]  ob_user = 8'ha5, ob_user_inv = 8'h5a;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        busy_flag, fast_mode_lock, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, target_location;
  logic [15:0] lfsr_r = 16'h0dbb;
  logic [33:0] qr[$];
  logic [1:0]  qb[$];
  int          error_cnt = 0, cmp_count = 0;

  faopr_regs uut (.*);
  always #2.5 aclk = ~aclk;

  // lfsr source of random data
  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return {lfsr_r, ~lfsr_r};
  endfunction : rnd
  // expected option word with read code
  function automatic logic [33:0] opt();
    return {26'h0, ob_user[7:2], ob_rdp, ob_user != ~ob_user_inv};
  endfunction : opt
  task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  // write, either channel released when taken
  task automatic wr(input logic [31:0] a, v, input logic [1:0] r = faopr_pkg::RESP_OKAY);
    qb.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    qr.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // one-cycle pulse on start, done or relock
  task automatic pulse(input logic [2:0] p);
    @(posedge aclk);
    {op_start, op_done, lock_set} <= p;
    @(posedge aclk);
    {op_start, op_done, lock_set} <= 3'h0;
    @(posedge aclk);
  endtask : pulse
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : do_reset
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // monitor pops the oldest note per answer
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready) check("rd", {s_axi_rresp, s_axi_rdata}, qr.pop_front());
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, qb.pop_front());
  end
  initial
  begin
    #20000;
    error_cnt++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ob_wrp <= rnd();
    do_reset();
    rd(faopr_pkg::ADDR_OPTION, opt());
    rd(faopr_pkg::ADDR_KEY, '0);
    rd(32'h0000_0040, {faopr_pkg::RESP_SLVERR, 32'h0});
    wr(32'h0000_0040, 32'h0, faopr_pkg::RESP_SLVERR);
    wr(faopr_pkg::ADDR_WPROT, 32'h0);
    rd(faopr_pkg::ADDR_WPROT, {2'h0, ob_wrp});
    d = rnd();
    wr(faopr_pkg::ADDR_TARGET, d);
    rd(faopr_pkg::ADDR_TARGET, '0);
    check("target", target_location, d);
    pulse(3'h4);
    wr(faopr_pkg::ADDR_TARGET, ~d);
    check("target", target_location, d);
    check("busy", busy_flag, 1'b1);
    pulse(3'h2);
    check("busy", busy_flag, 1'b0);
    check("irq", irq, 1'b0);
    s_axi_wstrb <= 4'h1;
    wr(faopr_pkg::ADDR_TARGET, ~d);
    check("target", target_location, {d[31:8], ~d[7:0]});
    s_axi_wstrb <= 4'hf;
    rd(faopr_pkg::ADDR_IRQ_STAT, 34'h0_0000_000c);
    wr(faopr_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
    check("irq", irq, 1'b1);
    wr(faopr_pkg::ADDR_IRQ_STAT, 32'h0000_0008);
    check("irq", irq, 1'b0);
    wr(faopr_pkg::ADDR_KEY, faopr_pkg::FIRST_UNLOCK);
    wr(faopr_pkg::ADDR_KEY, faopr_pkg::SECOND_UNLOCK);
    repeat (3) @(posedge aclk);
    check("lock", fast_mode_lock, 1'b0);
    pulse(3'h1);
    check("lock", fast_mode_lock, 1'b1);
    wr(faopr_pkg::ADDR_KEY, faopr_pkg::FIRST_UNLOCK);
    wr(faopr_pkg::ADDR_TARGET, d);
    wr(faopr_pkg::ADDR_KEY, faopr_pkg::SECOND_UNLOCK);
    repeat (3) @(posedge aclk);
    check("lock", fast_mode_lock, 1'b1);
    ob_user_inv <= 8'h00;
    ob_rdp <= 1'b0;
    ob_wrp <= rnd();
    do_reset();
    rd(faopr_pkg::ADDR_OPTION, opt());
    rd(faopr_pkg::ADDR_WPROT, {2'h0, ob_wrp});
    wr(faopr_pkg::ADDR_KEY, faopr_pkg::FIRST_UNLOCK);
    wr(faopr_pkg::ADDR_KEY, faopr_pkg::SECOND_UNLOCK);
    repeat (3) @(posedge aclk);
    check("lock", fast_mode_lock, 1'b0);
    end_of_test();
  end
endmodule : faopr_regs_tb
